// File: epv_consts.svh
// Constants for the code memory programming and verify port
`ifndef EPV_CONSTS_SVH
`define EPV_CONSTS_SVH

`define EPV_CODE_AW 13
`define EPV_CODE_DEPTH 8192
`define EPV_ENC_AW 6
`define EPV_ENC_DEPTH 64
`define EPV_ERASED_BYTE 8'hFF
`define EPV_PULSES_PER_BYTE 3'h5
`define EPV_SIG_ADDR_MFG 13'h0030
`define EPV_SIG_ADDR_PART 13'h0031
`define EPV_SIG_MFG_CODE 8'h5A
`define EPV_SIG_PART_CODE 8'hA5

`define EPV_KEY_PGM_CODE 4'hB
`define EPV_KEY_PGM_ENC 4'hA
`define EPV_KEY_PGM_LB1 4'hF
`define EPV_KEY_PGM_LB2 4'hC
`define EPV_KEY_PGM_LB3 4'h5
`define EPV_KEY_VERIFY 4'h3
`define EPV_KEY_SIG 4'h0

`define EPV_REG_CTRL 4'h0
`define EPV_REG_STATUS 4'h4
`define EPV_CTRL_RESET 32'h0000_0001
`define EPV_CTRL_ENABLE_BIT 0
`define EPV_STATUS_LOCK_LSB 0
`define EPV_STATUS_EA_BIT 3
`define EPV_STATUS_CNT_LSB 4
`define EPV_STATUS_MODE_LSB 8

`endif

// File: epv_lock_decode.sv
// Protection level decode from the three lock bits
`timescale 1ns/1ps
module epv_lock_decode
    import epv_pkg::*;
(
    input wire epv_lock_t lock_bits_in,
    output logic write_block_out,
    output logic code_read_block_out,
    output logic verify_block_out,
    output logic ext_exec_block_out
);

    // Undefined combinations fall to the tightest level any set bit implies
    always_comb begin
        write_block_out = |lock_bits_in;
        code_read_block_out = |lock_bits_in;
        verify_block_out = lock_bits_in[1] | lock_bits_in[2];
        ext_exec_block_out = lock_bits_in[2];
    end

endmodule : epv_lock_decode

// File: epv_pkg.sv
// Types for the code memory programming and verify port
package epv_pkg;

    typedef enum logic [2:0] {
        EPV_MODE_IDLE = 3'b000,
        EPV_MODE_SIG = 3'b001,
        EPV_MODE_PGM_CODE = 3'b010,
        EPV_MODE_VERIFY = 3'b011,
        EPV_MODE_PGM_ENC = 3'b100,
        EPV_MODE_PGM_LB1 = 3'b101,
        EPV_MODE_PGM_LB2 = 3'b110,
        EPV_MODE_PGM_LB3 = 3'b111
    } epv_mode_e;

    typedef logic [2:0] epv_lock_t;

endpackage : epv_pkg

// File: epv_port.sv
// Code memory programming, verify and protection port with Avalon-MM status access
`timescale 1ns/1ps
`include "epv_consts.svh"
module epv_port
    import epv_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic rst_pin_in,
    input wire logic program_store_enable_n_in,
    input wire logic prog_strobe_in,
    input wire logic ext_access_prog_supply_in,
    input wire logic ext_access_prog_supply_vpp_in,
    input wire logic [7:0] port1_in,
    input wire logic [7:0] port2_in,
    input wire logic port3_bit7_in,
    input wire logic port3_bit6_in,
    input wire logic [7:0] port0_in,
    output logic [7:0] port0_out,
    output logic port0_oe_out,
    output logic code_read_ext_block_out,
    output logic ext_exec_block_out,
    output logic ea_effective_out,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);

    logic [7:0] code_mem [`EPV_CODE_DEPTH];
    logic [7:0] enc_table [`EPV_ENC_DEPTH];
    epv_lock_t lock_bits;
    epv_mode_e mode;
    epv_mode_e last_mode;
    logic [3:0] key;
    logic [`EPV_CODE_AW-1:0] addr;
    logic [`EPV_CODE_AW-1:0] last_addr;
    logic [7:0] code_byte;
    logic [7:0] enc_byte;
    logic [2:0] pulse_cnt;
    logic strobe_d;
    logic strobe_fall;
    logic strobe_rise;
    logic commit;
    logic write_block;
    logic verify_block;
    logic rst_pin_d;
    logic ea_latched;
    logic ctrl_enable;
    logic bus_ack;

    // Port 2 bits 7 and 6 are mode select, so only its low five bits address
    assign addr = {port2_in[4:0], port1_in};
    assign key = {port2_in[7], port2_in[6], port3_bit7_in, port3_bit6_in};
    assign code_byte = code_mem[addr];
    assign enc_byte = enc_table[addr[`EPV_ENC_AW-1:0]];

    always_comb begin
        mode = EPV_MODE_IDLE;
        if (ctrl_enable && rst_pin_in && !program_store_enable_n_in) begin
            if (ext_access_prog_supply_vpp_in) begin
                case (key)
                    `EPV_KEY_PGM_CODE: mode = EPV_MODE_PGM_CODE;
                    `EPV_KEY_PGM_ENC: mode = EPV_MODE_PGM_ENC;
                    `EPV_KEY_PGM_LB1: mode = EPV_MODE_PGM_LB1;
                    `EPV_KEY_PGM_LB2: mode = EPV_MODE_PGM_LB2;
                    `EPV_KEY_PGM_LB3: mode = EPV_MODE_PGM_LB3;
                    default: mode = EPV_MODE_IDLE;
                endcase
            end else if (ext_access_prog_supply_in && prog_strobe_in) begin
                case (key)
                    `EPV_KEY_VERIFY: mode = EPV_MODE_VERIFY;
                    `EPV_KEY_SIG: mode = EPV_MODE_SIG;
                    default: mode = EPV_MODE_IDLE;
                endcase
            end
        end
    end

    epv_lock_decode u_lock (
        .lock_bits_in(lock_bits),
        .write_block_out(write_block),
        .code_read_block_out(code_read_ext_block_out),
        .verify_block_out(verify_block),
        .ext_exec_block_out(ext_exec_block_out)
    );

    // Strobe edges
    assign strobe_fall = strobe_d && !prog_strobe_in;
    assign strobe_rise = !strobe_d && prog_strobe_in;
    assign commit = strobe_rise && (pulse_cnt == `EPV_PULSES_PER_BYTE);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            strobe_d <= 1'b1;
        end else begin
            strobe_d <= prog_strobe_in;
        end
    end

    // A mode or address change mid-sequence restarts the count, so a byte
    // is only burned when all five pulses saw the same target
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pulse_cnt <= 3'h0;
            last_mode <= EPV_MODE_IDLE;
            last_addr <= '0;
        end else begin
            last_mode <= mode;
            last_addr <= addr;
            if (!mode[2] && mode != EPV_MODE_PGM_CODE) begin
                pulse_cnt <= 3'h0;
            end else if (mode != last_mode || addr != last_addr) begin
                pulse_cnt <= 3'h0;
            end else if (commit) begin
                pulse_cnt <= 3'h0;
            end else if (strobe_fall && pulse_cnt != `EPV_PULSES_PER_BYTE) begin
                pulse_cnt <= pulse_cnt + 3'h1;
            end
        end
    end

    // Cells only go from one to zero, as in a one-time array
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < `EPV_CODE_DEPTH; i++) begin
                code_mem[i] <= `EPV_ERASED_BYTE;
            end
        end else if (commit && mode == EPV_MODE_PGM_CODE && !write_block) begin
            code_mem[addr] <= code_mem[addr] & port0_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < `EPV_ENC_DEPTH; i++) begin
                enc_table[i] <= `EPV_ERASED_BYTE;
            end
        end else if (commit && mode == EPV_MODE_PGM_ENC && !write_block) begin
            enc_table[addr[`EPV_ENC_AW-1:0]] <= enc_table[addr[`EPV_ENC_AW-1:0]] & port0_in;
        end
    end

    // Lock writes stay open after the first lock bit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lock_bits <= 3'h0;
        end else if (commit) begin
            case (mode)
                EPV_MODE_PGM_LB1: lock_bits[0] <= 1'b1;
                EPV_MODE_PGM_LB2: lock_bits[1] <= 1'b1;
                EPV_MODE_PGM_LB3: lock_bits[2] <= 1'b1;
                default: lock_bits <= lock_bits;
            endcase
        end
    end

    // Port 0 read path; the table reaches it only through the XNOR
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            port0_out <= 8'h00;
            port0_oe_out <= 1'b0;
        end else if (mode == EPV_MODE_VERIFY && !verify_block) begin
            port0_out <= code_byte ~^ enc_byte;
            port0_oe_out <= 1'b1;
        end else if (mode == EPV_MODE_SIG) begin
            if (addr == `EPV_SIG_ADDR_MFG) begin
                port0_out <= `EPV_SIG_MFG_CODE;
            end else if (addr == `EPV_SIG_ADDR_PART) begin
                port0_out <= `EPV_SIG_PART_CODE;
            end else begin
                port0_out <= `EPV_ERASED_BYTE;
            end
            port0_oe_out <= 1'b1;
        end else begin
            port0_out <= 8'h00;
            port0_oe_out <= 1'b0;
        end
    end

    // Access pin is caught on the falling edge of the device reset pin
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rst_pin_d <= 1'b0;
            ea_latched <= 1'b0;
        end else begin
            rst_pin_d <= rst_pin_in;
            if (rst_pin_d && !rst_pin_in) begin
                ea_latched <= ext_access_prog_supply_in;
            end
        end
    end

    assign ea_effective_out = code_read_ext_block_out ? ea_latched
        : ext_access_prog_supply_in;

    // Avalon slave: one wait state on every access
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !bus_ack;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read_in || avs_write_in) && !bus_ack;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_enable <= 1'(`EPV_CTRL_RESET);
        end else if (avs_write_in && bus_ack && avs_address_in == `EPV_REG_CTRL) begin
            if (avs_byteenable_in[0]) begin
                ctrl_enable <= avs_writedata_in[`EPV_CTRL_ENABLE_BIT];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && !bus_ack) begin
            avs_readdata_out <= 32'h0000_0000;
            if (avs_address_in == `EPV_REG_CTRL) begin
                avs_readdata_out[`EPV_CTRL_ENABLE_BIT] <= ctrl_enable;
            end else if (avs_address_in == `EPV_REG_STATUS) begin
                avs_readdata_out[`EPV_STATUS_LOCK_LSB +: 3] <= lock_bits;
                avs_readdata_out[`EPV_STATUS_EA_BIT] <= ea_latched;
                avs_readdata_out[`EPV_STATUS_CNT_LSB +: 3] <= pulse_cnt;
                avs_readdata_out[`EPV_STATUS_MODE_LSB +: 3] <= mode;
            end
        end
    end

    // Checks
    logic [7:0] mem_at_addr;
    logic read_mode;
    assign mem_at_addr = code_mem[addr];
    assign read_mode = (mode == EPV_MODE_VERIFY) || (mode == EPV_MODE_SIG);

    property p_code_commit;
        @(posedge clk_in) disable iff (rst_in)
        (commit && mode == EPV_MODE_PGM_CODE && !write_block)
            |=> (code_mem[$past(addr)] == ($past(mem_at_addr) & $past(port0_in)));
    endproperty
    a_code_commit: assert property (p_code_commit) else $error("code byte not burned");

    property p_locked_no_write;
        @(posedge clk_in) disable iff (rst_in)
        (commit && mode == EPV_MODE_PGM_CODE && lock_bits != 3'h0)
            |=> (code_mem[$past(addr)] == $past(mem_at_addr));
    endproperty
    a_locked_no_write: assert property (p_locked_no_write) else $error("write while locked");

    property p_lb2_set;
        @(posedge clk_in) disable iff (rst_in)
        (commit && mode == EPV_MODE_PGM_LB2) |=> lock_bits[1] ##1 lock_bits[1];
    endproperty
    a_lb2_set: assert property (p_lb2_set) else $error("lock bit 2 not kept");

    property p_verify_data;
        @(posedge clk_in) disable iff (rst_in)
        (mode == EPV_MODE_VERIFY && !verify_block)
            |=> (port0_oe_out && port0_out == ($past(code_byte) ~^ $past(enc_byte)));
    endproperty
    a_verify_data: assert property (p_verify_data) else $error("verify data wrong");

    property p_verify_blocked;
        @(posedge clk_in) disable iff (rst_in)
        (mode == EPV_MODE_VERIFY && lock_bits[1]) |=> !port0_oe_out;
    endproperty
    a_verify_blocked: assert property (p_verify_blocked) else $error("verify not disabled");

    property p_sig_mfg;
        @(posedge clk_in) disable iff (rst_in)
        (mode == EPV_MODE_SIG && addr == `EPV_SIG_ADDR_MFG)
            |=> (port0_oe_out && port0_out == `EPV_SIG_MFG_CODE);
    endproperty
    a_sig_mfg: assert property (p_sig_mfg) else $error("signature byte wrong");

    property p_table_erased;
        @(posedge clk_in) rst_in |=> (enc_byte == `EPV_ERASED_BYTE);
    endproperty
    a_table_erased: assert property (p_table_erased) else $error("table not erased");

    property p_drive_only_reads;
        @(posedge clk_in) disable iff (rst_in)
        port0_oe_out |-> $past(read_mode);
    endproperty
    a_drive_only_reads: assert property (p_drive_only_reads) else $error("port 0 driven");

    property p_level4;
        @(posedge clk_in) disable iff (rst_in)
        lock_bits[2] |-> (ext_exec_block_out && code_read_ext_block_out);
    endproperty
    a_level4: assert property (p_level4) else $error("level 4 protection missing");

    property p_ea_latched;
        @(posedge clk_in) disable iff (rst_in)
        lock_bits[0] |-> (ea_effective_out == ea_latched);
    endproperty
    a_ea_latched: assert property (p_ea_latched) else $error("access pin not latched");

    property p_bus_answer;
        @(posedge clk_in) disable iff (rst_in)
        $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_code_burn: cover property (@(posedge clk_in) commit && mode == EPV_MODE_PGM_CODE);
    c_enc_burn: cover property (@(posedge clk_in) commit && mode == EPV_MODE_PGM_ENC);
    c_lock3: cover property (@(posedge clk_in) lock_bits == 3'h7);
    c_verify: cover property (@(posedge clk_in) port0_oe_out && enc_byte != 8'hFF);

endmodule : epv_port

// File: epv_prog_model.sv
// Programmer model driving the mode pins, address and data ports
`timescale 1ns/1ps
module epv_prog_model (
    input wire logic clk_in,
    input wire logic [7:0] dev_data_in,
    input wire logic dev_oe_in,
    output logic rst_pin_out,
    output logic store_n_out,
    output logic strobe_out,
    output logic access_out,
    output logic vpp_out,
    output logic [7:0] port1_out,
    output logic [7:0] port2_out,
    output logic p3b7_out,
    output logic p3b6_out,
    output logic [7:0] port0_out
);
    logic [7:0] drive_data;
    logic drive_en;
    // A released port 0 floats up to the pull-up level
    assign port0_out = dev_oe_in ? dev_data_in : (drive_en ? drive_data : 8'hFF);
    initial begin
        rst_pin_out = 1'b1;
        store_n_out = 1'b1;
        strobe_out = 1'b1;
        access_out = 1'b1;
        vpp_out = 1'b0;
        port1_out = 8'h00;
        port2_out = 8'h00;
        p3b7_out = 1'b0;
        p3b6_out = 1'b0;
        drive_data = 8'h00;
        drive_en = 1'b0;
    end
    task automatic set_pins(input logic [3:0] key, input logic vpp, input logic [12:0] addr,
            input logic [7:0] data, input logic store_n);
        @(posedge clk_in);
        store_n_out <= store_n;
        vpp_out <= vpp;
        port1_out <= addr[7:0];
        port2_out <= {key[3:2], 1'b0, addr[12:8]};
        p3b7_out <= key[1];
        p3b6_out <= key[0];
        drive_data <= data;
        drive_en <= vpp;
    endtask : set_pins
    task automatic prog_byte(input logic [3:0] key, input logic [12:0] addr,
            input logic [7:0] data, input int pulses);
        set_pins(key, 1'b1, addr, data, 1'b0);
        repeat (2) @(posedge clk_in);
        repeat (pulses) begin
            strobe_out <= 1'b0;
            repeat (2) @(posedge clk_in);
            strobe_out <= 1'b1;
            repeat (2) @(posedge clk_in);
        end
        // Address stays put while leaving the mode; port 0 is released as vpp drops
        set_pins(4'h0, 1'b0, addr, data, 1'b1);
    endtask : prog_byte
    task automatic read_byte(input logic [3:0] key, input logic [12:0] addr,
            output logic [7:0] data, output logic oe);
        set_pins(key, 1'b0, addr, 8'h00, 1'b0);
        repeat (2) @(posedge clk_in);
        #1;
        data = dev_data_in;
        oe = dev_oe_in;
        set_pins(4'h0, 1'b0, addr, 8'h00, 1'b1);
    endtask : read_byte
    task automatic set_access(input logic level);
        @(posedge clk_in);
        access_out <= level;
    endtask : set_access
    task automatic pulse_reset_pin();
        @(posedge clk_in);
        rst_pin_out <= 1'b0;
        @(posedge clk_in);
        rst_pin_out <= 1'b1;
    endtask : pulse_reset_pin
endmodule : epv_prog_model

// File: tb_epv_port.sv
// Self-checking bench for the programming and verify port
`timescale 1ns/1ps
`include "epv_consts.svh"
module tb_epv_port;
    import epv_pkg::*;
    logic clk_in, rst_in, avs_read_in, avs_write_in;
    logic [3:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd;
    logic avs_waitrequest_out, rst_pin, store_n, strobe, access, vpp, p3b7, p3b6;
    logic [7:0] p1, p2, p0, dout, d;
    logic doe, rd_blk, exec_blk, ea_eff, oe;
    int errors = 0;
    int checks = 0;
    epv_port dut_u (.clk_in(clk_in), .rst_in(rst_in), .rst_pin_in(rst_pin),
        .program_store_enable_n_in(store_n), .prog_strobe_in(strobe),
        .ext_access_prog_supply_in(access), .ext_access_prog_supply_vpp_in(vpp),
        .port1_in(p1), .port2_in(p2), .port3_bit7_in(p3b7), .port3_bit6_in(p3b6),
        .port0_in(p0), .port0_out(dout), .port0_oe_out(doe), .code_read_ext_block_out(rd_blk),
        .ext_exec_block_out(exec_blk), .ea_effective_out(ea_eff),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out));
    epv_prog_model pm_u (.clk_in(clk_in), .dev_data_in(dout), .dev_oe_in(doe),
        .rst_pin_out(rst_pin), .store_n_out(store_n), .strobe_out(strobe),
        .access_out(access), .vpp_out(vpp), .port1_out(p1), .port2_out(p2),
        .p3b7_out(p3b7), .p3b6_out(p3b6), .port0_out(p0));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic tally_and_finish();
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic do_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
    endtask : do_reset
    // Wait states are not assumed; right after an edge the design outputs still show
    // their pre-edge values, as every design register updates by non-blocking assignment
    task automatic avs_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
            output logic [31:0] rdata);
        int n = 0;
        @(posedge clk_in);
        avs_read_in <= !wr;
        avs_write_in <= wr;
        avs_address_in <= addr;
        avs_writedata_in <= wdata;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        chk("waitrequest", 32'h0, {31'h0, avs_waitrequest_out});
        rdata = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask : avs_xfer
    task automatic verify(input logic [12:0] a, input logic [7:0] exp, input logic exp_oe);
        pm_u.read_byte(`EPV_KEY_VERIFY, a, d, oe);
        chk("verify_oe", {31'h0, exp_oe}, {31'h0, oe});
        if (exp_oe) chk("verify_data", {24'h0, exp}, {24'h0, d});
    endtask : verify
    task automatic t_regs();
        avs_xfer(1'b0, `EPV_REG_STATUS, 32'h0, rd);
        chk("status", 32'h0, rd);
        avs_xfer(1'b0, `EPV_REG_CTRL, 32'h0, rd);
        chk("ctrl", `EPV_CTRL_RESET, rd);
        avs_xfer(1'b1, 4'h8, 32'hFFFF_FFFF, rd);
        avs_xfer(1'b0, 4'h8, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
    endtask : t_regs
    task automatic t_erased();
        verify(13'h0123, `EPV_ERASED_BYTE, 1'b1);
        verify(13'h1FFF, `EPV_ERASED_BYTE, 1'b1);
    endtask : t_erased
    task automatic t_code();
        pm_u.prog_byte(`EPV_KEY_PGM_CODE, 13'h0005, 8'h3C, 5);
        verify(13'h0005, 8'h3C, 1'b1);
        // Four pulses fall short of a byte write
        pm_u.prog_byte(`EPV_KEY_PGM_CODE, 13'h0007, 8'h00, 4);
        verify(13'h0007, 8'hFF, 1'b1);
    endtask : t_code
    task automatic t_sig();
        pm_u.read_byte(`EPV_KEY_SIG, `EPV_SIG_ADDR_MFG, d, oe);
        chk("sig_mfg", {24'h0, `EPV_SIG_MFG_CODE}, {24'h0, d});
        pm_u.read_byte(`EPV_KEY_SIG, `EPV_SIG_ADDR_PART, d, oe);
        chk("sig_part", {24'h0, `EPV_SIG_PART_CODE}, {24'h0, d});
    endtask : t_sig
    task automatic t_ctrl();
        avs_xfer(1'b1, `EPV_REG_CTRL, 32'h0, rd);
        verify(13'h0005, 8'h00, 1'b0);
        avs_xfer(1'b1, `EPV_REG_CTRL, 32'h1, rd);
        verify(13'h0005, 8'h3C, 1'b1);
    endtask : t_ctrl
    task automatic t_encrypt();
        pm_u.prog_byte(`EPV_KEY_PGM_ENC, 13'h0005, 8'h0F, 5);
        verify(13'h0005, ~(8'h3C ^ 8'h0F), 1'b1);
        verify(13'h0045, ~(8'hFF ^ 8'h0F), 1'b1);
    endtask : t_encrypt
    task automatic t_locks();
        pm_u.set_access(1'b0);
        #6 chk("ea_live", 32'h0, {31'h0, ea_eff});
        pm_u.set_access(1'b1);
        pm_u.pulse_reset_pin();
        pm_u.prog_byte(`EPV_KEY_PGM_LB1, 13'h0000, 8'h00, 5);
        chk("ext_read_block", 32'h1, {31'h0, rd_blk});
        chk("exec_block", 32'h0, {31'h0, exec_blk});
        avs_xfer(1'b0, `EPV_REG_STATUS, 32'h0, rd);
        chk("status_lock", 32'h9, rd & 32'hF);
        pm_u.prog_byte(`EPV_KEY_PGM_CODE, 13'h0010, 8'h00, 5);
        pm_u.prog_byte(`EPV_KEY_PGM_ENC, 13'h0010, 8'h00, 5);
        verify(13'h0010, 8'hFF, 1'b1);
        pm_u.set_access(1'b0);
        #6 chk("ea_latched", 32'h1, {31'h0, ea_eff});
        pm_u.set_access(1'b1);
        pm_u.prog_byte(`EPV_KEY_PGM_LB2, 13'h0000, 8'h00, 5);
        verify(13'h0005, 8'h00, 1'b0);
        pm_u.prog_byte(`EPV_KEY_PGM_LB3, 13'h0000, 8'h00, 5);
        chk("exec_block", 32'h1, {31'h0, exec_blk});
        avs_xfer(1'b0, `EPV_REG_STATUS, 32'h0, rd);
        chk("status_lock", 32'h7, rd & 32'h7);
    endtask : t_locks
    task automatic t_undefined();
        do_reset();
        pm_u.prog_byte(`EPV_KEY_PGM_LB2, 13'h0000, 8'h00, 5);
        chk("ext_read_block", 32'h1, {31'h0, rd_blk});
        verify(13'h0005, 8'h00, 1'b0);
    endtask : t_undefined
    initial begin
        rst_in = 1'b1;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 4'h0;
        avs_writedata_in = 32'h0;
        do_reset();
        t_regs();
        t_erased();
        t_code();
        t_sig();
        t_ctrl();
        t_encrypt();
        t_locks();
        t_undefined();
        tally_and_finish();
    end
    // The whole run takes a few hundred cycles; this cuts a hang short
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule : tb_epv_port
